// ### snsr_regs.sv
/*
 * Register bank of the motion sensor behind its four-wire serial port:
 * reset and shutdown commands, inverse identity, axis snapping, motion
 * burst, firmware load burst and pixel burst.
 * Assumes SPI mode 3 framing from the host; all port pins are async and
 * are synchronised to core_clk; the serial clock is much slower than core_clk.
 */
`timescale 1ns/1ps
// Function
// R1: Writing 0x5A to the power-up reset register resets every setting to its default.
// R2: The host issues the reset command after shutdown and after frame capture.
// R3: Writing 0xB6 to the shutdown register enters shutdown, left only by the reset command.
// R4: Address 0x3F reads the bitwise inverse of the part identity.
// R5: Bit 7 of the snapping register enables axis snapping, the other bits are reserved.
// R6: With snapping on, motion within 5 degrees of an axis is reported on that axis.
// R7: The snapping register is read/write and holds 0x06 after reset.
// R8: Reading the motion burst register streams the thirteen motion values in order.
// R9: Any write to the motion burst register discards the held motion burst data.
// R10: The firmware load register accepts a continuous stream of firmware bytes; the code drops bytes that arrive while its 16-byte buffer is full.
// R11: Each pixel burst read returns the next pixel and advances, 900 per frame.
// R12: The power-up reset register sits at 0x3A and is write-only.
// R13: The host sets the firmware size bit before streaming firmware.
// R14: Every access is a four-wire serial transaction framed by active-low chip select.
module snsr_regs
    import snsr_regs_pkg::*;
#(
    parameter logic [7:0] PART_IDENTITY = 8'h5C // Arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ncs,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    input  wire logic signed [15:0] raw_dx,
    input  wire logic signed [15:0] raw_dy,
    input  wire logic [7:0]  motion_status,
    input  wire logic [7:0]  surface_quality,
    input  wire logic [7:0]  pixel_sum,
    input  wire logic [7:0]  max_pixel,
    input  wire logic [7:0]  min_pixel,
    input  wire logic [15:0] shutter,
    input  wire logic [15:0] frame_period,
    input  wire logic        motion_latch,
    input  wire logic [7:0]  pixel_data,
    output logic [9:0]       pixel_index,
    output logic [7:0]       fw_data,
    output logic             fw_valid,
    input  wire logic        fw_ready,
    output logic             firmware_size_select,
    output logic             snap_enable,
    output logic             shutdown,
    output logic             chip_reset,
    output logic signed [15:0] snapped_dx,
    output logic signed [15:0] snapped_dy
);
    // -------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------------
    logic [1:0] ncs_s;
    logic [1:0] sclk_s;
    logic [1:0] mosi_s;
    logic       sclk_d;
    logic       ncs_d;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_start;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ncs_s  <= 2'h3;
            sclk_s <= 2'h3;
            mosi_s <= 2'h0;
            sclk_d <= 1'b1;
            ncs_d  <= 1'b1;
        end
        else
        begin
            ncs_s  <= {ncs_s[0], ncs};
            sclk_s <= {sclk_s[0], sclk};
            mosi_s <= {mosi_s[0], mosi};
            sclk_d <= sclk_s[1];
            ncs_d  <= ncs_s[1];
        end
    end

    assign sclk_rise   = !ncs_s[1] && sclk_s[1] && !sclk_d;
    assign sclk_fall   = !ncs_s[1] && !sclk_s[1] && sclk_d;
    assign frame_start = !ncs_s[1] && ncs_d;

    // -------------------------------------------------------------------
    // Serial engine
    // -------------------------------------------------------------------
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [2:0] bit_cnt;
    logic       have_addr;
    logic       is_write;
    logic [6:0] addr;
    logic [7:0] snap_reg;
    logic [7:0] size_reg;
    logic [3:0] mb_idx;
    logic       mb_valid;
    logic [9:0] pix_ptr;
    logic       shut;
    logic [7:0] next_shift_in;
    logic [7:0] next_shift_out;
    logic [2:0] next_bit_cnt;
    logic       next_have_addr;
    logic       next_is_write;
    logic [6:0] next_addr;
    logic [7:0] next_snap_reg;
    logic [7:0] next_size_reg;
    logic [3:0] next_mb_idx;
    logic       next_mb_valid;
    logic [9:0] next_pix_ptr;
    logic       next_shut;
    logic       next_chip_reset;
    logic [7:0] byte_in;
    logic       byte_done;
    logic [7:0] mb_byte;
    logic [7:0] rd_byte;
    logic       fifo_in_valid;
    logic       fifo_in_ready;

    assign byte_in   = {shift_in[6:0], mosi_s[1]};
    assign byte_done = sclk_rise && bit_cnt == 3'h7;

    // Motion burst byte order
    always_comb
    begin
        case (mb_idx)
            4'h0:    mb_byte = motion_status;
            4'h1:    mb_byte = snapped_dx[7:0];
            4'h2:    mb_byte = snapped_dx[15:8];
            4'h3:    mb_byte = snapped_dy[7:0];
            4'h4:    mb_byte = snapped_dy[15:8];
            4'h5:    mb_byte = surface_quality;
            4'h6:    mb_byte = pixel_sum;
            4'h7:    mb_byte = max_pixel;
            4'h8:    mb_byte = min_pixel;
            4'h9:    mb_byte = shutter[15:8];
            4'hA:    mb_byte = shutter[7:0];
            4'hB:    mb_byte = frame_period[15:8];
            4'hC:    mb_byte = frame_period[7:0];
            default: mb_byte = 8'h00;
        endcase
    end

    // Read data for the byte that follows an address
    always_comb
    begin
        case (byte_in[6:0])
            ADDR_INVERSE_IDENTITY: rd_byte = ~PART_IDENTITY; // R4
            ADDR_AXIS_SNAP:        rd_byte = snap_reg; // R7
            ADDR_SIZE_SELECT:      rd_byte = size_reg;
            ADDR_MOTION_BURST:     rd_byte = mb_valid ? motion_status : 8'h00; // R8
            ADDR_PIXEL_BURST:      rd_byte = pixel_data; // R11
            default:               rd_byte = 8'h00; // R12
        endcase
    end

    assign fifo_in_valid = byte_done && have_addr && is_write && addr == ADDR_FIRMWARE_LOAD; // R10

    always_comb
    begin
        next_shift_in   = shift_in;
        next_shift_out  = shift_out;
        next_bit_cnt    = bit_cnt;
        next_have_addr  = have_addr;
        next_is_write   = is_write;
        next_addr       = addr;
        next_snap_reg   = snap_reg;
        next_size_reg   = size_reg;
        next_mb_idx     = mb_idx;
        next_mb_valid   = mb_valid;
        next_pix_ptr    = pix_ptr;
        next_shut       = shut;
        next_chip_reset = 1'b0;
        if (frame_start) // R14
        begin
            next_bit_cnt   = 3'h0;
            next_have_addr = 1'b0;
            next_mb_idx    = 4'h0;
            next_shift_out = 8'h00;
        end
        // First fall of a byte presents the freshly loaded MSB, later falls shift
        else if (sclk_fall && bit_cnt != 3'h0)
        begin
            next_shift_out = {shift_out[6:0], 1'b0};
        end
        else if (sclk_rise)
        begin
            next_shift_in = byte_in;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (byte_done && !have_addr)
            begin
                next_have_addr = 1'b1;
                next_is_write  = byte_in[ADDR_BIT_WRITE];
                next_addr      = byte_in[6:0];
                if (!byte_in[ADDR_BIT_WRITE])
                begin
                    next_shift_out = rd_byte;
                    if (byte_in[6:0] == ADDR_MOTION_BURST)
                        next_mb_idx = 4'h1;
                    if (byte_in[6:0] == ADDR_PIXEL_BURST)
                        next_pix_ptr = (pix_ptr == 10'(PIXEL_COUNT - 1)) ? 10'h000 : pix_ptr + 10'h001; // R11
                end
            end
            else if (byte_done && is_write && addr != ADDR_FIRMWARE_LOAD)
            begin
                next_have_addr = 1'b0;
                case (addr)
                    ADDR_POWER_UP_RESET: // R1 R12
                        if (byte_in == RESET_COMMAND)
                        begin
                            next_chip_reset = 1'b1;
                            next_snap_reg   = AXIS_SNAP_RESET;
                            next_size_reg   = SIZE_SEL_RESET;
                            next_mb_valid   = 1'b0;
                            next_pix_ptr    = 10'h000;
                            next_shut       = 1'b0;
                        end
                    ADDR_SHUTDOWN_COMMAND:
                        if (byte_in == SHUTDOWN_CODE)
                            next_shut = 1'b1; // R3
                    ADDR_AXIS_SNAP:
                        next_snap_reg = byte_in; // R5 R7
                    ADDR_SIZE_SELECT:
                        next_size_reg = byte_in; // R13
                    ADDR_MOTION_BURST:
                        next_mb_valid = 1'b0; // R9
                    default:
                        next_have_addr = 1'b0;
                endcase
            end
            else if (byte_done && !is_write && addr == ADDR_MOTION_BURST)
            begin
                next_shift_out = (mb_valid && mb_idx < 4'(MOTION_BYTES)) ? mb_byte : 8'h00; // R8
                next_mb_idx    = mb_idx + 4'h1;
            end
            else if (byte_done && !is_write && addr == ADDR_PIXEL_BURST)
            begin
                next_shift_out = pixel_data;
                next_pix_ptr   = (pix_ptr == 10'(PIXEL_COUNT - 1)) ? 10'h000 : pix_ptr + 10'h001; // R11
            end
        end
        // A new capture outranks a clear in the same cycle
        if (motion_latch)
        begin
            next_mb_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            shift_in   <= 8'h00;
            shift_out  <= 8'h00;
            bit_cnt    <= 3'h0;
            have_addr  <= 1'b0;
            is_write   <= 1'b0;
            addr       <= 7'h00;
            snap_reg   <= AXIS_SNAP_RESET;
            size_reg   <= SIZE_SEL_RESET;
            mb_idx     <= 4'h0;
            mb_valid   <= 1'b0;
            pix_ptr    <= 10'h000;
            shut       <= 1'b0;
            chip_reset <= 1'b0;
        end
        else
        begin
            shift_in   <= next_shift_in;
            shift_out  <= next_shift_out;
            bit_cnt    <= next_bit_cnt;
            have_addr  <= next_have_addr;
            is_write   <= next_is_write;
            addr       <= next_addr;
            snap_reg   <= next_snap_reg;
            size_reg   <= next_size_reg;
            mb_idx     <= next_mb_idx;
            mb_valid   <= next_mb_valid;
            pix_ptr    <= next_pix_ptr;
            shut       <= next_shut;
            chip_reset <= next_chip_reset;
        end
    end

    assign miso                 = shift_out[7];
    assign miso_oe              = !ncs_s[1];
    assign pixel_index          = pix_ptr;
    assign snap_enable          = snap_reg[SNAP_EN_BIT]; // R5
    assign firmware_size_select = size_reg[SIZE_SEL_BIT];
    assign shutdown             = shut;

    // -------------------------------------------------------------------
    // Firmware byte buffer
    // -------------------------------------------------------------------
    snsr_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_fw_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_data   (byte_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fw_data),
        .out_valid (fw_valid),
        .out_ready (fw_ready)
    );

    // -------------------------------------------------------------------
    // Axis snapping: tan(5 deg) ~ 11/128
    // -------------------------------------------------------------------
    logic [15:0] abs_x;
    logic [15:0] abs_y;
    logic [23:0] x_scaled;
    logic [23:0] y_scaled;

    always_comb
    begin
        abs_x      = raw_dx[15] ? 16'(-raw_dx) : raw_dx;
        abs_y      = raw_dy[15] ? 16'(-raw_dy) : raw_dy;
        x_scaled   = 24'(abs_x) * 24'(SNAP_TAN_NUM);
        y_scaled   = 24'(abs_y) * 24'(SNAP_TAN_NUM);
        snapped_dx = raw_dx;
        snapped_dy = raw_dy;
        if (snap_enable && {abs_y, 7'h00} <= 23'(x_scaled)) // R6
            snapped_dy = 16'h0000;
        else if (snap_enable && {abs_x, 7'h00} <= 23'(y_scaled)) // R6
            snapped_dx = 16'h0000;
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    snap_reset_a: assert property (@(posedge core_clk) $rose(rst_n) |-> snap_reg == AXIS_SNAP_RESET) // R7
        else $error("snap register not at reset value");
    reset_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        chip_reset |-> snap_reg == AXIS_SNAP_RESET && !shut && pix_ptr == 10'h000) // R1
        else $error("reset command left state behind");
    shut_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        shut && !next_chip_reset |=> shut) // R3
        else $error("shutdown left without reset");
    snap_en_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        byte_done && have_addr && is_write && addr == ADDR_AXIS_SNAP |=> snap_enable == $past(byte_in[SNAP_EN_BIT])) // R5
        else $error("snap enable mismatch");
    snap_axis_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !snap_enable |-> snapped_dx == raw_dx && snapped_dy == raw_dy) // R6
        else $error("snapping while disabled");
    burst_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        byte_done && have_addr && is_write && addr == ADDR_MOTION_BURST && !motion_latch |=> !mb_valid) // R9
        else $error("motion burst not cleared");
    pixel_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pix_ptr < 10'(PIXEL_COUNT)) // R11
        else $error("pixel pointer out of range");
    fw_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fifo_in_valid && fifo_in_ready |=> fw_valid) // R10
        else $error("firmware byte lost");
    miso_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ncs_s[1] |-> !miso_oe) // R14
        else $error("miso driven while deselected");
endmodule

// ### snsr_regs_pkg.sv
/*
 * Constants for the sensor register bank: addresses, command codes, reset
 * values and the burst sizes.
 * Assumes a 7-bit address space reached over a four-wire serial port.
 */
package snsr_regs_pkg;
    // -------------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------------
    localparam logic [6:0] ADDR_POWER_UP_RESET   = 7'h3A;
    localparam logic [6:0] ADDR_SHUTDOWN_COMMAND = 7'h3B;
    localparam logic [6:0] ADDR_INVERSE_IDENTITY = 7'h3F;
    localparam logic [6:0] ADDR_AXIS_SNAP        = 7'h42;
    localparam logic [6:0] ADDR_MOTION_BURST     = 7'h50;
    localparam logic [6:0] ADDR_FIRMWARE_LOAD    = 7'h62;
    localparam logic [6:0] ADDR_PIXEL_BURST      = 7'h64;
    localparam logic [6:0] ADDR_SIZE_SELECT      = 7'h39;
    // -------------------------------------------------------------------
    // Commands, fields and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RESET_COMMAND    = 8'h5A;
    localparam logic [7:0] SHUTDOWN_CODE    = 8'hB6;
    localparam logic [7:0] AXIS_SNAP_RESET  = 8'h06;
    localparam logic [7:0] SIZE_SEL_RESET   = 8'h00;
    localparam int         SNAP_EN_BIT      = 7;
    localparam int         SIZE_SEL_BIT     = 1;
    localparam logic [7:0] SNAP_TAN_NUM     = 8'h0B;
    localparam int         MOTION_BYTES     = 13;
    localparam int         PIXEL_COUNT      = 900;
    localparam int         ADDR_BIT_WRITE   = 7;
endpackage

// ### snsr_fifo.sv
/*
 * Small first-in first-out buffer with valid/ready on both sides.
 * Assumes a single clock; depth is a power of two.
 */
`timescale 1ns/1ps
module snsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule

// ### spi_host.sv
/*
 * Host side of the sensor's four-wire serial port: mode 3 frames, MSB first.
 * Assumes the bench calls its tasks and that the core clock runs at 100 MHz.
 */
`timescale 1ns/1ps
module spi_host (
    input  wire logic core_clk,
    output logic      ncs,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // ---------------------------------------------------------------
    // Frame timing
    // ---------------------------------------------------------------
    // Eight core cycles per half period gives a 160 ns serial clock
    localparam int HALF = 8;

    initial
    begin
        ncs  = 1'b1;
        sclk = 1'b1;
        mosi = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic open_frame();
        wait_clk(1);
        ncs = 1'b0;
        wait_clk(HALF);
    endtask

    // Released data line shows the inverse of its last value
    task automatic close_frame();
        wait_clk(HALF);
        ncs  = 1'b1;
        mosi = ~mosi;
        wait_clk(2 * HALF);
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclk = 1'b0;
            mosi = tx[i];
            wait_clk(HALF);
            sclk  = 1'b1;
            rx[i] = miso & miso_oe;
            wait_clk(HALF);
        end
    endtask

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        open_frame();
        xfer({1'b1, addr}, rx);
        xfer(data, rx);
        close_frame();
    endtask

    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        logic [7:0] rx;
        open_frame();
        xfer({1'b0, addr}, rx);
        xfer(8'h00, data);
        close_frame();
    endtask
endmodule

// ### testbench.sv
/*
 * Self-checking bench for the sensor register bank, driven through the host model.
 * Assumes the core values are live inputs and pixels are looked up by index.
 */
`timescale 1ns/1ps
module testbench
    import snsr_regs_pkg::*;
;
    localparam logic [7:0] ID = 8'h71; // Arbitrary value
    logic core_clk = 1'b0, rst_n = 1'b0, motion_latch = 1'b0, fw_ready = 1'b1;
    logic ncs, sclk, mosi, miso, miso_oe, fw_valid, firmware_size_select, snap_enable, shutdown, chip_reset;
    logic signed [15:0] raw_dx = 16'sh0000, raw_dy = 16'sh0000, snapped_dx, snapped_dy;
    logic [7:0] motion_status = 8'h00, surface_quality = 8'h00, pixel_sum = 8'h00, max_pixel = 8'h00;
    logic [7:0] min_pixel = 8'h00, pixel_data, fw_data;
    logic [15:0] shutter = 16'h0000, frame_period = 16'h0000;
    logic [9:0] pixel_index;
    logic [7:0] rd;
    int fail_count = 0, n_tests = 0, resets_seen = 0;

    always #5 core_clk = ~core_clk;
    assign pixel_data = pixel_index[7:0] ^ 8'h3C;
    always @(posedge core_clk) if (chip_reset) resets_seen++;

    spi_host host (.core_clk, .ncs, .sclk, .mosi, .miso, .miso_oe);
    snsr_regs #(.PART_IDENTITY(ID)) i_dut (.core_clk, .rst_n, .ncs, .sclk, .mosi, .miso, .miso_oe,
        .raw_dx, .raw_dy, .motion_status, .surface_quality, .pixel_sum, .max_pixel, .min_pixel,
        .shutter, .frame_period, .motion_latch, .pixel_data, .pixel_index, .fw_data, .fw_valid,
        .fw_ready, .firmware_size_select, .snap_enable, .shutdown, .chip_reset, .snapped_dx, .snapped_dy);

    // ---------------------------------------------------------------
    // Reporting
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        host.read_reg(ADDR_AXIS_SNAP, rd);
        check("snap reset", 16'h0006, rd);
        host.read_reg(ADDR_INVERSE_IDENTITY, rd);
        check("inverse id", {8'h00, ~ID}, rd);
        host.write_reg(ADDR_INVERSE_IDENTITY, 8'h00);
        host.read_reg(ADDR_INVERSE_IDENTITY, rd);
        check("inverse id kept", {8'h00, ~ID}, rd);
        host.read_reg(ADDR_POWER_UP_RESET, rd);
        check("reset reg read", 16'h0000, rd);
        host.read_reg(ADDR_SHUTDOWN_COMMAND, rd);
        check("shutdown reg read", 16'h0000, rd);
        host.read_reg(7'h10, rd);
        check("unmapped read", 16'h0000, rd);
        check("snap off", 16'h0000, snap_enable);
    endtask

    task automatic t_motion();
        logic [7:0] exp [14];
        @(negedge core_clk);
        {motion_status, raw_dx, raw_dy, surface_quality} = {8'h81, 16'h1234, 16'hFEDC, 8'h55};
        {pixel_sum, max_pixel, min_pixel, shutter, frame_period} = {24'h667788, 16'hA1A2, 16'hB1B2};
        motion_latch = 1'b1;
        @(negedge core_clk);
        motion_latch = 1'b0;
        exp = '{8'h81, 8'h34, 8'h12, 8'hDC, 8'hFE, 8'h55, 8'h66, 8'h77, 8'h88, 8'hA1, 8'hA2, 8'hB1, 8'hB2, 8'h00};
        host.open_frame();
        host.xfer({1'b0, ADDR_MOTION_BURST}, rd);
        for (int k = 0; k < 14; k++)
        begin
            host.xfer(8'h00, rd);
            check("motion byte", {8'h00, exp[k]}, rd);
        end
        host.close_frame();
        host.write_reg(ADDR_MOTION_BURST, 8'h3C);
        host.read_reg(ADDR_MOTION_BURST, rd);
        check("motion cleared", 16'h0000, rd);
    endtask

    task automatic t_snap();
        logic signed [15:0] tab [5][4];
        tab = '{'{100, 5, 100, 0}, '{100, -5, 100, 0}, '{3, -200, 0, -200}, '{100, 40, 100, 40}, '{-90, 2, -90, 0}};
        host.write_reg(ADDR_AXIS_SNAP, 8'h80);
        host.read_reg(ADDR_AXIS_SNAP, rd);
        check("snap bit", 16'h0001, rd[SNAP_EN_BIT]);
        check("snap enable", 16'h0001, snap_enable);
        for (int k = 0; k < 5; k++)
        begin
            raw_dx = tab[k][0];
            raw_dy = tab[k][1];
            @(negedge core_clk);
            check("snapped dx", tab[k][2], snapped_dx);
            check("snapped dy", tab[k][3], snapped_dy);
        end
        host.write_reg(ADDR_AXIS_SNAP, 8'h00);
        check("snap disable", 16'h0000, snap_enable);
        check("unsnapped dy", 16'sd2, snapped_dy);
    endtask

    task automatic t_firmware();
        int n;
        host.write_reg(ADDR_SIZE_SELECT, 8'h02);
        check("size select", 16'h0001, firmware_size_select);
        fw_ready = 1'b0;
        host.open_frame();
        host.xfer({1'b1, ADDR_FIRMWARE_LOAD}, rd);
        for (int k = 0; k < 18; k++) host.xfer(8'h40 + 8'(k), rd);
        host.close_frame();
        n = 0;
        for (int c = 0; c < 80; c++)
        begin
            @(negedge core_clk);
            fw_ready = c[0];
            if (fw_valid && fw_ready)
            begin
                check("fw byte", 16'h0040 + 16'(n), fw_data);
                n++;
            end
        end
        check("fw count", 16'd16, 16'(n));
        check("fw empty", 16'h0000, fw_valid);
    endtask

    task automatic t_pixel();
        host.open_frame();
        host.xfer({1'b0, ADDR_PIXEL_BURST}, rd);
        for (int k = 0; k < 20; k++)
        begin
            host.xfer(8'h00, rd);
            check("pixel", {8'h00, 8'(k) ^ 8'h3C}, rd);
        end
        host.close_frame();
    endtask

    task automatic t_commands();
        int r;
        host.write_reg(ADDR_AXIS_SNAP, 8'h80);
        host.write_reg(ADDR_SHUTDOWN_COMMAND, SHUTDOWN_CODE);
        check("shutdown set", 16'h0001, shutdown);
        r = resets_seen;
        host.write_reg(ADDR_POWER_UP_RESET, 8'h5B);
        check("no reset on other code", 16'(r), 16'(resets_seen));
        host.write_reg(ADDR_POWER_UP_RESET, RESET_COMMAND);
        check("reset pulses", 16'(r + 1), 16'(resets_seen));
        check("shutdown left", 16'h0000, shutdown);
        check("snap default", 16'h0000, snap_enable);
        check("size default", 16'h0000, firmware_size_select);
        host.read_reg(ADDR_AXIS_SNAP, rd);
        check("snap reg default", 16'h0006, rd);
        host.read_reg(ADDR_PIXEL_BURST, rd);
        check("pixel restart", 16'h003C, rd);
    endtask

    // ---------------------------------------------------------------
    // Sequence and watchdog
    // ---------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_reset_values();
        t_motion();
        t_snap();
        t_firmware();
        t_pixel();
        t_commands();
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
endmodule
